// ===== pocl_pkg.sv
// Package for the PWM output chop and lock slice: register map and field layout.
// Assumes an APB slave with 32-bit data; all registers are aligned words.
package pocl_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_TIME_BASE  = 8'h00;
   localparam logic [7:0] OFF_OUT_CTRL   = 8'h04;
   localparam logic [7:0] OFF_UNLOCK_KEY = 8'h08;
   localparam logic [7:0] OFF_AUX_CTRL   = 8'h0c;
   localparam logic [7:0] OFF_GEN_CTRL   = 8'h10;
   localparam logic [7:0] OFF_STATUS     = 8'h14;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MODULE_ENABLE_BIT = 15;
   localparam int HIGH_OWN_BIT      = 15;
   localparam int LOW_OWN_BIT       = 14;
   localparam int HIGH_POL_BIT      = 13;
   localparam int LOW_POL_BIT       = 12;
   localparam int FAULT_STATE_LSB   = 4;
   localparam int CL_ENABLE_BIT     = 24;
   localparam int CL_SRC_LSB        = 26;
   localparam int FAULT_MODE_LSB    = 16;
   localparam int FAULT_SRC_LSB     = 19;
   localparam int CHOP_SEL_LSB      = 2;
   localparam int HIGH_CHOP_BIT     = 1;
   localparam int LOW_CHOP_BIT      = 0;
   localparam int DTC_LSB           = 6;

   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [31:0] OUT_CTRL_RST  = 32'h0078_0000;
   localparam logic [31:0] OUT_CTRL_MASK = 32'h3d7f_f030;
   localparam logic [31:0] KEY_FIRST     = 32'h0000_abcd;
   localparam logic [31:0] KEY_SECOND    = 32'h0000_4321;
   localparam logic [3:0]  CHOP_MAX_SEL  = 4'hc;
   localparam logic [1:0]  DTC_ON_CODE   = 2'h3;
   localparam int          DTC_FAULT_IN  = 3;
   localparam int          NUM_FAULT_IN  = 15;

   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_OPEN} pocl_key_t;

   typedef struct packed {
      logic high_own;
      logic low_own;
      logic high_pol;
      logic low_pol;
      logic [1:0] fault_state;
   } pocl_pin_cfg_t;
endpackage

// ===== pocl_top.sv
// PWM output pin ownership, fault override, unlock-key protection and chopping.
// Assumes APB master on clk; fault inputs synchronous; pwm_h/pwm_l from the core.
`timescale 1ns/10ps
`default_nettype none

module pocl_top #(
   parameter int NUM_GEN = 12
) (
   // Clock and reset
   input  wire  logic                 clk,
   input  wire  logic                 srst,
   // APB slave
   input  wire  logic                 psel,
   input  wire  logic                 penable,
   input  wire  logic                 pwrite,
   input  wire  logic [7:0]           paddr,
   input  wire  logic [31:0]          pwdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic [31:0]                prdata,
   // Fuse and PWM core
   input  wire  logic                 lock_fuse,
   input  wire  logic                 pwm_h,
   input  wire  logic                 pwm_l,
   input  wire  logic                 chop_clk,
   input  wire  logic [NUM_GEN-1:0]   gen_high_outputs,
   // Shared fault inputs, index 0 is input 1
   input  wire  logic [14:0]          shared_fault_input,
   // Power stage pins
   output logic                       high_output,
   output logic                       low_output,
   output logic                       high_pin_own,
   output logic                       low_pin_own,
   output logic                       fault_active,
   output logic                       current_limit_active,
   output logic                       deadtime_comp_input
);

   // ---------------------------------------------------------------
   // Registers and bus decode
   // ---------------------------------------------------------------
   logic [31:0]         time_base_control_r;
   logic [31:0]         output_control_register_r;
   logic [5:0]          auxiliary_control_r;
   logic [1:0]          deadtime_comp_control_r;
   pocl_pkg::pocl_key_t key_r;
   pocl_pkg::pocl_pin_cfg_t pin_cfg;
   logic                acc;
   logic                wr;
   logic                known;
   logic                out_wr_ok;
   logic                high_raw;
   logic                low_raw;
   logic                chop_sig;
   logic                fault_sel;
   logic                cl_sel;

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign pready  = 1'b1;
   assign known   = paddr == pocl_pkg::OFF_TIME_BASE || paddr == pocl_pkg::OFF_OUT_CTRL ||
                    paddr == pocl_pkg::OFF_UNLOCK_KEY || paddr == pocl_pkg::OFF_AUX_CTRL ||
                    paddr == pocl_pkg::OFF_GEN_CTRL || paddr == pocl_pkg::OFF_STATUS;
   assign pslverr = acc & ~known;

   // Fault input pick: code n routes input n+1 (index n)
   function automatic logic pick_fault(input logic [14:0] ins, input logic [3:0] code);
      pick_fault = (code < 4'(pocl_pkg::NUM_FAULT_IN)) ? ins[code] : 1'b0;
   endfunction

   // ---------------------------------------------------------------
   // Unlock key sequence
   // ---------------------------------------------------------------
   // Any access other than the expected next one drops the sequence, except a first key write, which always restarts it
   always_ff @(posedge clk) begin
      if (srst) begin
         key_r <= pocl_pkg::KEY_IDLE;
      end else if (acc) begin
         if (wr && paddr == pocl_pkg::OFF_UNLOCK_KEY && pwdata == pocl_pkg::KEY_FIRST) begin
            key_r <= pocl_pkg::KEY_GOT_FIRST;
         end else if (wr && paddr == pocl_pkg::OFF_UNLOCK_KEY &&
                      pwdata == pocl_pkg::KEY_SECOND && key_r == pocl_pkg::KEY_GOT_FIRST) begin
            key_r <= pocl_pkg::KEY_OPEN;
         end else begin
            key_r <= pocl_pkg::KEY_IDLE;
         end
      end
   end

   // Fuse at 1 leaves the register open; a key pair opens it for one access
   assign out_wr_ok = lock_fuse || key_r == pocl_pkg::KEY_OPEN;

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         output_control_register_r <= pocl_pkg::OUT_CTRL_RST;
      end else if (wr && paddr == pocl_pkg::OFF_OUT_CTRL && out_wr_ok) begin
         output_control_register_r <= pwdata & pocl_pkg::OUT_CTRL_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         time_base_control_r <= 32'h0000_0000;
      end else if (wr && paddr == pocl_pkg::OFF_TIME_BASE) begin
         time_base_control_r <= {16'h0000, pwdata[pocl_pkg::MODULE_ENABLE_BIT], 15'h0000};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         auxiliary_control_r <= 6'h00;
      end else if (wr && paddr == pocl_pkg::OFF_AUX_CTRL) begin
         auxiliary_control_r <= pwdata[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         deadtime_comp_control_r <= 2'h0;
      end else if (wr && paddr == pocl_pkg::OFF_GEN_CTRL) begin
         deadtime_comp_control_r <= pwdata[pocl_pkg::DTC_LSB +: 2];
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            pocl_pkg::OFF_TIME_BASE:  prdata <= time_base_control_r;
            pocl_pkg::OFF_OUT_CTRL:   prdata <= output_control_register_r;
            pocl_pkg::OFF_AUX_CTRL:   prdata <= {26'h0000000, auxiliary_control_r};
            pocl_pkg::OFF_GEN_CTRL:   prdata <= {24'h000000, deadtime_comp_control_r, 6'h00};
            pocl_pkg::OFF_STATUS:     prdata <= {27'h0000000, key_r == pocl_pkg::KEY_OPEN,
                                                 deadtime_comp_input, current_limit_active,
                                                 fault_active, lock_fuse};
            default:                  prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Fault, current limit and compensation routing
   // ---------------------------------------------------------------
   assign fault_sel = pick_fault(shared_fault_input,
                      output_control_register_r[pocl_pkg::FAULT_SRC_LSB +: 4]);
   assign cl_sel    = pick_fault(shared_fault_input,
                      output_control_register_r[pocl_pkg::CL_SRC_LSB +: 4]);

   always_ff @(posedge clk) begin
      if (srst) begin
         fault_active         <= 1'b0;
         current_limit_active <= 1'b0;
         deadtime_comp_input  <= 1'b0;
      end else begin
         // Fault mode field value 3 disables the fault override
         fault_active <= fault_sel &&
                         output_control_register_r[pocl_pkg::FAULT_MODE_LSB +: 2] != 2'h3;
         current_limit_active <= cl_sel && output_control_register_r[pocl_pkg::CL_ENABLE_BIT];
         deadtime_comp_input <= deadtime_comp_control_r == pocl_pkg::DTC_ON_CODE &&
                                shared_fault_input[pocl_pkg::DTC_FAULT_IN-1];
      end
   end

   // ---------------------------------------------------------------
   // Output pins
   // ---------------------------------------------------------------
   assign pin_cfg = '{high_own:    output_control_register_r[pocl_pkg::HIGH_OWN_BIT],
                      low_own:     output_control_register_r[pocl_pkg::LOW_OWN_BIT],
                      high_pol:    output_control_register_r[pocl_pkg::HIGH_POL_BIT],
                      low_pol:     output_control_register_r[pocl_pkg::LOW_POL_BIT],
                      fault_state: output_control_register_r[pocl_pkg::FAULT_STATE_LSB +: 2]};

   // Chop source 0 is the chop clock, 1..12 pick a generator high output
   always_comb begin
      chop_sig = 1'b0;
      if (auxiliary_control_r[5:2] == 4'h0) begin
         chop_sig = chop_clk;
      end else if (auxiliary_control_r[5:2] <= pocl_pkg::CHOP_MAX_SEL &&
                   int'(auxiliary_control_r[5:2]) <= NUM_GEN) begin
         chop_sig = gen_high_outputs[auxiliary_control_r[5:2] - 4'h1];
      end
   end

   // Fault wins over current limit; current limit forces both inactive
   always_comb begin
      if (fault_active) begin
         high_raw = pin_cfg.fault_state[1] ^ pin_cfg.high_pol;
         low_raw  = pin_cfg.fault_state[0] ^ pin_cfg.low_pol;
      end else if (current_limit_active) begin
         high_raw = pin_cfg.high_pol;
         low_raw  = pin_cfg.low_pol;
      end else begin
         high_raw = (auxiliary_control_r[pocl_pkg::HIGH_CHOP_BIT] ? pwm_h & chop_sig : pwm_h)
                    ^ pin_cfg.high_pol;
         low_raw  = (auxiliary_control_r[pocl_pkg::LOW_CHOP_BIT] ? pwm_l & chop_sig : pwm_l)
                    ^ pin_cfg.low_pol;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         high_output  <= 1'b0;
         low_output   <= 1'b0;
         high_pin_own <= 1'b0;
         low_pin_own  <= 1'b0;
      end else begin
         high_output  <= high_raw;
         low_output   <= low_raw;
         high_pin_own <= pin_cfg.high_own;
         low_pin_own  <= pin_cfg.low_own;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_locked_write: assert property (@(posedge clk) disable iff (srst)
      wr && paddr == pocl_pkg::OFF_OUT_CTRL && !lock_fuse && key_r != pocl_pkg::KEY_OPEN
      |=> $stable(output_control_register_r))
      else $error("locked output control changed");
   chk_key_open: assert property (@(posedge clk) disable iff (srst)
      $rose(key_r == pocl_pkg::KEY_OPEN) |-> $past(pwdata) == pocl_pkg::KEY_SECOND)
      else $error("unlock without second key");
   chk_key_drop: assert property (@(posedge clk) disable iff (srst)
      key_r == pocl_pkg::KEY_OPEN && acc |=> key_r != pocl_pkg::KEY_OPEN)
      else $error("unlock outlived one access");
   chk_aux_zero: assert property (@(posedge clk) disable iff (srst)
      $past(psel && !penable && !pwrite && paddr == pocl_pkg::OFF_AUX_CTRL)
      |-> prdata[31:6] == 26'h0)
      else $error("aux upper bits not zero");
   chk_own_follow: assert property (@(posedge clk) disable iff (srst)
      ##1 high_pin_own == $past(output_control_register_r[pocl_pkg::HIGH_OWN_BIT]))
      else $error("high ownership mismatch");
   chk_fault_drive: assert property (@(posedge clk) disable iff (srst)
      fault_active |=> high_output == $past(pin_cfg.fault_state[1] ^ pin_cfg.high_pol))
      else $error("fault level wrong");
   chk_dtc_route: assert property (@(posedge clk) disable iff (srst)
      deadtime_comp_control_r == 2'h3 && shared_fault_input[2] |=> deadtime_comp_input)
      else $error("compensation input missed");
   chk_chop_gate: assert property (@(posedge clk) disable iff (srst)
      !fault_active && !current_limit_active && auxiliary_control_r[1] && !chop_sig
      && !pin_cfg.high_pol |=> !high_output)
      else $error("chop did not gate high");
   chk_fault_pick: assert property (@(posedge clk) disable iff (srst)
      output_control_register_r[22:19] == 4'h7 |-> fault_sel == shared_fault_input[7])
      else $error("fault source wrong");

   // Key sequence and write protection
   chk_key_first: assert property (@(posedge clk) disable iff (srst)
      $rose(key_r == pocl_pkg::KEY_GOT_FIRST) |-> $past(pwdata) == pocl_pkg::KEY_FIRST)
      else $error("first key state without first key");
   chk_open_write: assert property (@(posedge clk) disable iff (srst)
      wr && paddr == pocl_pkg::OFF_OUT_CTRL && out_wr_ok
      |=> output_control_register_r == $past(pwdata & pocl_pkg::OUT_CTRL_MASK))
      else $error("open output control write lost");

   // Pin levels and ownership
   chk_low_own: assert property (@(posedge clk) disable iff (srst)
      ##1 low_pin_own == $past(output_control_register_r[pocl_pkg::LOW_OWN_BIT]))
      else $error("low ownership mismatch");
   chk_cl_force: assert property (@(posedge clk) disable iff (srst)
      current_limit_active && !fault_active
      |=> high_output == $past(pin_cfg.high_pol) && low_output == $past(pin_cfg.low_pol))
      else $error("current limit level wrong");
   chk_low_chop: assert property (@(posedge clk) disable iff (srst)
      !fault_active && !current_limit_active && auxiliary_control_r[0] && !chop_sig
      && !pin_cfg.low_pol |=> !low_output)
      else $error("chop did not gate low");
   chk_chop_reserved: assert property (@(posedge clk) disable iff (srst)
      auxiliary_control_r[5:2] > pocl_pkg::CHOP_MAX_SEL |-> !chop_sig)
      else $error("reserved chop code passed a signal");

   // Source routing
   chk_cl_pick: assert property (@(posedge clk) disable iff (srst)
      output_control_register_r[29:26] == 4'h6 |-> cl_sel == shared_fault_input[6])
      else $error("current limit source wrong");
   chk_dtc_off: assert property (@(posedge clk) disable iff (srst)
      deadtime_comp_control_r != pocl_pkg::DTC_ON_CODE |=> !deadtime_comp_input)
      else $error("compensation input without enable");

endmodule

`default_nettype wire

// ===== pocl_stage_model.sv
// Power stage fault sensing model: raises shared fault lines by input number.
// Assumes numbers 1 to 15 address the lines and 0 leaves every line quiet.
`timescale 1ns/10ps
`default_nettype none
module pocl_stage_model (
   // Sensor requests, by fault input number
   input  wire logic [3:0]  fault_num,
   input  wire logic [3:0]  limit_num,
   // Shared fault lines, bit n is input n+1, active high
   output logic      [14:0] shared_fault_input
);
   // Fault and current-limit sensors each raise the line they number; both can raise the same line
   always_comb begin
      shared_fault_input = 15'h0;
      if (fault_num != 4'h0)
         shared_fault_input[fault_num - 4'h1] = 1'b1;
      if (limit_num != 4'h0)
         shared_fault_input[limit_num - 4'h1] = 1'b1;
   end
endmodule
`default_nettype wire

// ===== tb_pwm_output_chop_and_lock.sv
// Self-checking bench for the PWM output chop and lock slice.
// Assumes pocl_pkg, pocl_top and pocl_stage_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_output_chop_and_lock;
   logic        clk, srst, psel, penable, pwrite, lock_fuse, pwm_h, pwm_l, chop_clk;
   logic        pready, pslverr, err, h_out, l_out, h_own, l_own, f_act, cl_act, dtc_in;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [11:0] gen_hi;
   logic [3:0]  f_num, l_num;
   logic [14:0] sfi;
   int          bad_count, total_checks;

   pocl_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .lock_fuse(lock_fuse), .pwm_h(pwm_h), .pwm_l(pwm_l), .chop_clk(chop_clk),
      .gen_high_outputs(gen_hi), .shared_fault_input(sfi), .high_output(h_out),
      .low_output(l_out), .high_pin_own(h_own), .low_pin_own(l_own), .fault_active(f_act),
      .current_limit_active(cl_act), .deadtime_comp_input(dtc_in));
   pocl_stage_model stage (.fault_num(f_num), .limit_num(l_num), .shared_fault_input(sfi));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         bad_count++;
         conclude();
      end
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic unlock;
      wr(pocl_pkg::OFF_UNLOCK_KEY, 32'h0000_abcd);
      wr(pocl_pkg::OFF_UNLOCK_KEY, 32'h0000_4321);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic fin(input logic [3:0] f, input logic [3:0] l);
      @(posedge clk);
      f_num <= f;
      l_num <= l;
      settle();
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("out_ctrl reset", q, 32'h0078_0000);
      chk("own reset", 32'({h_own, l_own}), 32'h0);
      rd(pocl_pkg::OFF_AUX_CTRL);
      chk("aux reset", q, 32'h0);
      rd(8'h18);
      chk("unmapped err", 32'(err), 32'h1);
      $display("t_reset done");
   endtask
   task automatic t_lock;
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0000_c000);
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("no key", q, 32'h0078_0000);
      wr(pocl_pkg::OFF_UNLOCK_KEY, 32'h0000_4321);
      wr(pocl_pkg::OFF_UNLOCK_KEY, 32'h0000_abcd);
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0000_c000);
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("key reversed", q, 32'h0078_0000);
      unlock();
      rd(pocl_pkg::OFF_TIME_BASE);
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0000_c000);
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("key interrupted", q, 32'h0078_0000);
      unlock();
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0078_c000);
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0);
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("key once", q, 32'h0078_c000);
      chk("both own", 32'({h_own, l_own}), 32'h3);
      @(posedge clk);
      lock_fuse <= 1'b1;
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0078_4000);
      rd(pocl_pkg::OFF_OUT_CTRL);
      chk("fuse open", q, 32'h0078_4000);
      settle();
      chk("low own", 32'({h_own, l_own}), 32'h1);
      $display("t_lock done");
   endtask
   task automatic t_route;
      for (int c = 0; c < 15; c++) begin
         wr(pocl_pkg::OFF_OUT_CTRL, 32'h0103_c000 | (32'(c) << 26));
         fin(4'h0, 4'(c + 1));
         chk("limit source", 32'(cl_act), 32'h1);
         fin(4'h0, 4'((c + 1) % 15 + 1));
         chk("limit other", 32'(cl_act), 32'h0);
         wr(pocl_pkg::OFF_OUT_CTRL, 32'h0000_c000 | (32'(c) << 19));
         fin(4'(c + 1), 4'h0);
         chk("fault source", 32'(f_act), 32'h1);
         fin(4'((c + 1) % 15 + 1), 4'h0);
         chk("fault other", 32'(f_act), 32'h0);
      end
      $display("t_route done");
   endtask
   task automatic t_fault;
      logic [31:0] cfg [4] = '{32'h0038_c020, 32'h0038_e020, 32'h0038_d030, 32'h1938_c030};
      logic [1:0]  exp [4] = '{2'b10, 2'b00, 2'b10, 2'b11};
      @(posedge clk);
      pwm_h <= 1'b1;
      pwm_l <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(pocl_pkg::OFF_OUT_CTRL, cfg[i]);
         fin(4'h8, 4'h7);
         chk("fault pins", 32'({h_out, l_out}), 32'(exp[i]));
      end
      chk("fault wins", 32'(f_act), 32'h1);
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h193b_c030);
      settle();
      chk("limit pins", 32'({h_out, l_out, cl_act}), 32'h1);
      $display("t_fault done");
   endtask
   task automatic t_dtc;
      wr(pocl_pkg::OFF_GEN_CTRL, 32'h0000_00c0);
      fin(4'h3, 4'h0);
      chk("dtc on 3", 32'(dtc_in), 32'h1);
      rd(pocl_pkg::OFF_STATUS);
      chk("status", q, 32'h0000_0009);
      fin(4'h4, 4'h0);
      chk("dtc on 4", 32'(dtc_in), 32'h0);
      wr(pocl_pkg::OFF_GEN_CTRL, 32'h0000_0080);
      fin(4'h3, 4'h0);
      chk("dtc off", 32'(dtc_in), 32'h0);
      $display("t_dtc done");
   endtask
   task automatic t_chop;
      wr(pocl_pkg::OFF_OUT_CTRL, 32'h0078_c000);
      fin(4'h0, 4'h0);
      wr(pocl_pkg::OFF_AUX_CTRL, 32'hffff_ffc2);
      rd(pocl_pkg::OFF_AUX_CTRL);
      chk("aux upper", q, 32'h0000_0002);
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         chop_clk <= b[0];
         settle();
         chk("high chop", 32'({h_out, l_out}), 32'({b[0], 1'b1}));
      end
      for (int s = 1; s < 16; s++) begin
         wr(pocl_pkg::OFF_AUX_CTRL, 32'(s) << 2 | 32'h1);
         @(posedge clk);
         gen_hi <= 12'h1 << (s - 1);
         settle();
         chk("chop select", 32'({h_out, l_out}), 32'({1'b1, s < 13}));
         @(posedge clk);
         gen_hi <= ~(12'h1 << (s - 1));
         settle();
         chk("low chop", 32'(l_out), 32'h0);
      end
      wr(pocl_pkg::OFF_TIME_BASE, 32'h0000_8000);
      settle();
      chk("own enabled", 32'({h_own, l_own}), 32'h3);
      $display("t_chop done");
   endtask

   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, lock_fuse, pwm_h, pwm_l, chop_clk} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      gen_hi = 12'h0;
      f_num = 4'h0;
      l_num = 4'h0;
      bad_count = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_lock();
      t_route();
      t_fault();
      t_dtc();
      t_chop();
      conclude();
   end
endmodule
`default_nettype wire
